/* rtl/ashp_port.sv */
`timescale 1ns/100ps
module ashp_port
(
   // system side
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // serial pins
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic frame_sync_in_i,
   input wire logic clock_polarity_select_i,
   input wire logic sdata_i,
   output logic sdata_o,
   output logic sdata_oe_o,
   output logic eoc_o,
   // converter core
   output ashp_pkg::ashp_cmd_t conv_cmd_o,
   output logic conv_start_o,
   input wire logic conv_done_i,
   input wire logic [9:0] conv_result_i,
   // status
   output logic mp_mode_o
);
   logic mode_mp_ff;
   logic frame_rst;
   logic [3:0] rcnt_ff;
   logic [3:0] fcnt_ff;
   logic [3:0] cmd_r_ff;
   logic [3:0] cmd_f_ff;
   logic tog_r_ff;
   logic tog_f_ff;
   logic [3:0] hold_r_ff;
   logic [3:0] hold_f_ff;
   logic tenth_r;
   logic tenth_f;
   logic cap_on_rise;
   logic [3:0] cmd_link;
   logic [3:0] out_idx;
   logic tog_r_sync;
   logic tog_r_stable;
   logic tog_f_sync;
   logic tog_f_stable;
   logic seen_r_ff;
   logic seen_f_ff;
   logic evt_r;
   logic evt_f;
   logic [3:0] cmd_sel;
   logic start_evt;
   ashp_pkg::ashp_state_t state_ff;
   ashp_pkg::ashp_state_t nxt_state;
   logic [9:0] result_ff;
   ashp_pkg::ashp_cmd_t cmd_ff;
   logic start_ff;

   // framing mode caught at each chip select fall
   always_ff @(negedge cs_n_i)
   begin
      mode_mp_ff <= frame_sync_in_i;
   end

   // frame reset: chip select high, or frame sync high in dsp framing
   assign frame_rst = cs_n_i | (~mode_mp_ff & frame_sync_in_i);
   // capture edge: mp+pol high or dsp+pol low use rising edges
   assign cap_on_rise = ~(mode_mp_ff ^ clock_polarity_select_i);

   // rising-edge side of the link
   always_ff @(posedge sclk_i or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         rcnt_ff <= 4'h0;
         cmd_r_ff <= ashp_pkg::CMD_RST;
      end
      else
      begin
         if (rcnt_ff != ashp_pkg::CNT_MAX)
         begin
            rcnt_ff <= rcnt_ff + 4'h1;
         end
         if (rcnt_ff < ashp_pkg::CMD_EDGES)
         begin
            cmd_r_ff <= {cmd_r_ff[2:0], sdata_i};
         end
      end
   end

   // falling-edge side of the link
   always_ff @(negedge sclk_i or posedge frame_rst)
   begin
      if (frame_rst)
      begin
         fcnt_ff <= 4'h0;
         cmd_f_ff <= ashp_pkg::CMD_RST;
      end
      else
      begin
         if (fcnt_ff != ashp_pkg::CNT_MAX)
         begin
            fcnt_ff <= fcnt_ff + 4'h1;
         end
         if (fcnt_ff < ashp_pkg::CMD_EDGES)
         begin
            cmd_f_ff <= {cmd_f_ff[2:0], sdata_i};
         end
      end
   end

   // selection between the two edge sides
   assign cmd_link = cap_on_rise ? cmd_r_ff : cmd_f_ff;
   // tenth edge: rises count in microprocessor framing, falls in dsp framing
   assign tenth_r = mode_mp_ff & (rcnt_ff == ashp_pkg::TENTH_EDGE_IDX);
   assign tenth_f = ~mode_mp_ff & (fcnt_ff == ashp_pkg::TENTH_EDGE_IDX);
   // mp shifts on falls, dsp on rises; index saturates past the last bit
   assign out_idx = mode_mp_ff ? fcnt_ff : rcnt_ff;
   // result word is held still while busy, so the link may read it directly
   assign sdata_o = (out_idx < ashp_pkg::OUT_BITS) ? result_ff[4'd9 - out_idx] : 1'b0;
   assign sdata_oe_o = ~cs_n_i;
   assign mp_mode_o = mode_mp_ff;

   // tenth-edge toggles stay out of the frame reset, so a host that raises chip
   // select right after the tenth edge still gets its conversion and its command;
   // rst_i clears them directly because the serial clock rests while idle
   always_ff @(posedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tog_r_ff <= 1'b0;
         hold_r_ff <= ashp_pkg::CMD_RST;
      end
      else if (tenth_r)
      begin
         tog_r_ff <= ~tog_r_ff;
         hold_r_ff <= cmd_link;
      end
   end

   // falling-edge twin for dsp framing
   always_ff @(negedge sclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         tog_f_ff <= 1'b0;
         hold_f_ff <= ashp_pkg::CMD_RST;
      end
      else if (tenth_f)
      begin
         tog_f_ff <= ~tog_f_ff;
         hold_f_ff <= cmd_link;
      end
   end

   // each toggle crosses through its own three-stage chain
   ashp_sync u_tog_r_sync
   (
      .clk_i(sys_clk_i),
      .rst_i(rst_i),
      .d_i(tog_r_ff),
      .q_o(tog_r_sync),
      .stable_o(tog_r_stable)
   );

   ashp_sync u_tog_f_sync
   (
      .clk_i(sys_clk_i),
      .rst_i(rst_i),
      .d_i(tog_f_ff),
      .q_o(tog_f_sync),
      .stable_o(tog_f_stable)
   );

   // a settled toggle that differs from the last one seen marks one tenth edge
   assign evt_r = tog_r_stable & (tog_r_sync ^ seen_r_ff);
   assign evt_f = tog_f_stable & (tog_f_sync ^ seen_f_ff);
   assign start_evt = evt_r | evt_f;
   // the hold word changed with its toggle, so it is long settled by now
   assign cmd_sel = evt_r ? hold_r_ff : hold_f_ff;

   // busy/ready sequencing
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         ashp_pkg::ASHP_READY:
         begin
            if (start_evt)
            begin
               nxt_state = ashp_pkg::ASHP_BUSY;
            end
         end
         ashp_pkg::ASHP_BUSY:
         begin
            if (conv_done_i)
            begin
               nxt_state = ashp_pkg::ASHP_READY;
            end
         end
         default:
         begin
            nxt_state = ashp_pkg::ASHP_READY;
         end
      endcase
   end

   // system-domain registers; command taken from the side whose toggle fired
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         state_ff <= ashp_pkg::ASHP_READY;
         seen_r_ff <= 1'b0;
         seen_f_ff <= 1'b0;
         result_ff <= ashp_pkg::RES_RST;
         cmd_ff <= '0;
         start_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (tog_r_stable)
         begin
            seen_r_ff <= tog_r_sync;
         end
         if (tog_f_stable)
         begin
            seen_f_ff <= tog_f_sync;
         end
         start_ff <= start_evt & (state_ff == ashp_pkg::ASHP_READY);
         if (start_evt & (state_ff == ashp_pkg::ASHP_READY))
         begin
            cmd_ff.code <= cmd_sel;
            cmd_ff.pwrdn <= (cmd_sel == ashp_pkg::CMD_PWRDN);
            cmd_ff.fast <= (cmd_sel == ashp_pkg::CMD_FAST);
         end
         if (conv_done_i & (state_ff == ashp_pkg::ASHP_BUSY))
         begin
            result_ff <= conv_result_i;
         end
      end
   end

   assign eoc_o = (state_ff == ashp_pkg::ASHP_READY);
   assign conv_cmd_o = cmd_ff;
   assign conv_start_o = start_ff;
endmodule : ashp_port

/* rtl/ashp_pkg.sv */
package ashp_pkg;
   localparam int CMD_W = 4;
   localparam int RES_W = 10;
   localparam int CNT_W = 4;
   // edge counts within a frame
   localparam logic [3:0] CMD_EDGES = 4'h4;
   localparam logic [3:0] TENTH_EDGE_IDX = 4'h9;
   localparam logic [3:0] CNT_MAX = 4'hF;
   localparam logic [3:0] OUT_BITS = 4'hA;
   // command codes that steer the converter instead of picking an input
   localparam logic [3:0] CMD_PWRDN = 4'hE;
   localparam logic [3:0] CMD_FAST = 4'hF;
   // reset values
   localparam logic [9:0] RES_RST = 10'h000;
   localparam logic [3:0] CMD_RST = 4'h0;

   // command handed to the converter core
   typedef struct packed {
      logic [3:0] code;
      logic pwrdn;
      logic fast;
   } ashp_cmd_t;

   typedef enum logic [1:0] {
      ASHP_READY = 2'b01,
      ASHP_BUSY = 2'b10
   } ashp_state_t;
endpackage : ashp_pkg

/* rtl/ashp_sync.sv */
`timescale 1ns/100ps
// three-stage synchroniser; stage one feeds only stage two
module ashp_sync
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // level in and out
   input wire logic d_i,
   output logic q_o,
   output logic stable_o
);
   logic s1_ff;
   logic s2_ff;
   logic s3_ff;

   // shift chain
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
      end
      else
      begin
         s1_ff <= d_i;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   // a change counts only once the last two stages agree
   assign q_o = s3_ff;
   assign stable_o = (s2_ff == s3_ff);
endmodule : ashp_sync

/* testbench/ashp_port_props.sv */
`timescale 1ns/100ps
// handshake rules watched from the system clock
module ashp_port_props
(
   // design ports
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic cs_n_i,
   input wire logic frame_sync_in_i,
   input wire logic sdata_oe_o,
   input wire logic eoc_o,
   input wire logic conv_start_o,
   input wire logic conv_done_i,
   input wire ashp_pkg::ashp_cmd_t conv_cmd_o,
   input wire logic mp_mode_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   a_oe_follows_cs: assert property (sdata_oe_o == !cs_n_i) else $error("oe off cs");
   a_start_drops_eoc: assert property (conv_start_o |-> $fell(eoc_o)) else $error("start without eoc fall");
   a_start_single: assert property (conv_start_o |=> !conv_start_o) else $error("start too long");
   a_busy_holds: assert property (!eoc_o && !conv_done_i |=> !eoc_o) else $error("busy lost");
   a_done_ready: assert property (!eoc_o && conv_done_i |=> eoc_o) else $error("eoc not back");
   a_pwrdn_code: assert property (conv_start_o |->
      conv_cmd_o.pwrdn == (conv_cmd_o.code == ashp_pkg::CMD_PWRDN)) else $error("pwrdn decode");
   a_fast_code: assert property (conv_start_o |->
      conv_cmd_o.fast == (conv_cmd_o.code == ashp_pkg::CMD_FAST)) else $error("fast decode");
   a_mode_latch: assert property ($fell(cs_n_i) && frame_sync_in_i |=> mp_mode_o) else $error("mode flag");
endmodule : ashp_port_props

bind ashp_port ashp_port_props props_u (.sys_clk_i, .rst_i, .cs_n_i, .frame_sync_in_i, .sdata_oe_o, .eoc_o,
   .conv_start_o, .conv_done_i, .conv_cmd_o, .mp_mode_o);

/* testbench/ashp_host.sv */
`timescale 1ns/100ps
// host serial port; its clock rests between frames
module ashp_host
(
   // serial pins
   output logic sclk_o,
   output logic cs_n_o,
   output logic fs_o,
   output logic pol_o,
   output logic sdata_o,
   input wire logic sdata_i
);
   initial
   begin
      {cs_n_o, fs_o, pol_o, sclk_o, sdata_o} = 5'b11100;
   end
   // one frame of n clocks; reads each bit just before a capture edge
   task automatic frame(input logic mp, input logic pl, input logic [3:0] c, input int n,
      output logic [10:0] r);
      logic cap;
      cap = (mp == pl);
      pol_o = pl;
      sclk_o = ~cap;
      fs_o = mp;
      #6 cs_n_o = 0;
      if (!mp)
      begin
         #6 fs_o = 1;
         #6 fs_o = 0;
      end
      for (int k = 0; k < n; k++)
      begin
         sdata_o = (k < 4) ? c[3 - k] : ~c[k % 4]; // junk after the command
         #6 if (k < 11) r[10 - k] = sdata_i;
         sclk_o = cap;
         #6 sclk_o = ~cap;
      end
      #6 cs_n_o = 1;
      sdata_o = ~sdata_o; // released line shows no stale value
   endtask : frame
endmodule : ashp_host

/* testbench/ashp_port_test.sv */
`timescale 1ns/100ps
module ashp_port_test;
   logic sys_clk_i = 0, rst_i = 1, conv_done_i = 0;
   logic [9:0] conv_result_i = 10'h000;
   logic [9:0] prev = ashp_pkg::RES_RST;
   logic sclk, cs_n, fs, pol, sdi, sdo, oe, eoc, start, mode, pin;
   logic [10:0] rd;
   ashp_pkg::ashp_cmd_t cmd, got;
   int err_count = 0, n_checks = 0, cyc = 0, n_start = 0;
   logic [3:0] cmds [6] = '{4'h5, 4'hE, 4'hA, 4'hF, 4'h3, 4'hC};
   always #20 sys_clk_i = ~sys_clk_i;
   ashp_port dut_u (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .frame_sync_in_i(fs),
      .clock_polarity_select_i(pol), .sdata_i(sdi), .sdata_o(sdo), .sdata_oe_o(oe), .eoc_o(eoc),
      .conv_cmd_o(cmd), .conv_start_o(start), .conv_done_i(conv_done_i), .conv_result_i(conv_result_i),
      .mp_mode_o(mode));
   // a line left floating shows the inverse here, never a stale bit
   assign pin = oe ? sdo : ~sdo;
   ashp_host host_u (.sclk_o(sclk), .cs_n_o(cs_n), .fs_o(fs), .pol_o(pol), .sdata_o(sdi), .sdata_i(pin));
   task automatic chk(input logic [10:0] s, input logic [10:0] e);
      n_checks++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : summarize
   // start is caught mid-cycle, away from the edge that launches it; also the hang limit
   always @(negedge sys_clk_i)
   begin
      cyc++;
      if (start === 1'b1)
      begin
         got = cmd;
         n_start++;
      end
      if (cyc == 3000)
      begin
         err_count++;
         summarize();
      end
   end
   // every framing and polarity pairing, 11 to 16 clocks
   initial
   begin
      repeat (20) @(posedge sys_clk_i);
      #1 rst_i = 0;
      repeat (4) @(posedge sys_clk_i);
      for (int i = 0; i < 6; i++)
      begin
         host_u.frame(i[0], i[1], cmds[i], 11 + i, rd);
         chk(rd, {prev, 1'b0});
         chk(mode, i[0]);
         for (int t = 0; t < 20 && eoc !== 1'b0; t++) @(posedge sys_clk_i);
         repeat (3) @(posedge sys_clk_i);
         #1 chk(eoc, 1'b0);
         chk(11'(n_start), 11'(i + 1));
         chk(got, {cmds[i], cmds[i] == ashp_pkg::CMD_PWRDN, cmds[i] == ashp_pkg::CMD_FAST});
         prev = {~cmds[i], 6'h35 ^ 6'(i)};
         conv_result_i = prev;
         conv_done_i = 1;
         @(posedge sys_clk_i);
         #1 conv_done_i = 0;
         chk(eoc, 1'b1);
      end
      summarize();
   end
endmodule : ashp_port_test
